/* pai_ext_exec.sv */
// execute unit for pointer literal add, add-and-return and call via working reg
// assumes fetch offers one word per cycle and the core applies pc and stack strobes
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pai_ext_exec
  import pai_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,

  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,

  // instruction fetch
  input  wire logic                  instr_valid,
  input  wire logic [15:0]           instr_word,
  output logic                       instr_ready,
  output logic                       instr_claimed,

  // core state
  input  wire logic [PC_W-1:0]       pc_now,
  input  wire logic [7:0]            working_reg_alias,
  input  wire logic [7:0]            pc_high_latch,
  input  wire logic [7:0]            pc_upper_latch,
  input  wire logic [PC_W-1:0]       top_of_return_stack,

  // pc and return stack control
  output logic                       pc_load,
  output logic [PC_W-1:0]            pc_load_value,
  output logic                       stack_push,
  output logic [PC_W-1:0]            stack_push_value,
  output logic                       stack_pop,

  // pointers
  output logic [PTR_W-1:0]           ptr_reg_0,
  output logic [PTR_W-1:0]           ptr_reg_1,
  output logic [PTR_W-1:0]           pointer_reg_two
);

  // ************************************************************
  // declarations
  // ************************************************************
  typedef enum logic {
    ST_RUN,
    ST_NOP
  } pai_state_t;

  // sequencing
  pai_state_t             state_q;
  pai_state_t             state_d;
  pai_op_t                op;
  logic [1:0]             op_sel;
  logic [LIT_W-1:0]       op_lit;
  logic                   ext_seen;
  logic                   accept;
  logic                   busy;

  // pointer add
  logic                   add_en;
  logic [1:0]             add_sel;
  logic [2:0][PTR_W-1:0]  ptr_all;

  // control, status and count
  logic                   ext_en_q;
  logic                   blocked_q;
  logic                   blocked_set;
  logic                   blocked_clr;
  logic [15:0]            count_q;
  logic [15:0]            count_d;

  // pc and stack strobes
  logic                   pc_load_q;
  logic [PC_W-1:0]        pc_load_value_q;
  logic                   stack_push_q;
  logic [PC_W-1:0]        stack_push_value_q;
  logic                   stack_pop_q;

  // bus
  logic                   ack_q;
  logic                   rd_capture;
  logic [31:0]            readdata_q;
  logic [31:0]            read_mux;
  logic                   bus_wr;
  logic                   ptr_wr;
  logic [1:0]             ptr_wr_sel;

  // ************************************************************
  // shared decode
  // ************************************************************
  // ops that hold fetch off for one idle cycle and take over the pc
  function automatic logic is_two_cycle(input pai_op_t o);
    return (o == OP_ADD_RET) || (o == OP_CALL_W);
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  pai_decode u_decode (
    .instr_word (instr_word),
    .ext_en     (ext_en_q),
    .op         (op),
    .sel        (op_sel),
    .lit        (op_lit),
    .ext_seen   (ext_seen)
  );

  // ************************************************************
  // instruction sequencing
  // ************************************************************
  // the second cycle of a two-cycle op refuses fetch so the core sees a nop;
  // ready is combinational so back to back plain adds never lose a cycle
  assign busy          = (state_q == ST_NOP);
  assign instr_ready   = ~busy;
  assign accept        = instr_valid & instr_ready;
  assign instr_claimed = accept & (op != OP_NONE);

  // two states suffice: the only wait any of the three ops needs is one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (accept && is_two_cycle(op)) begin
          state_d = ST_NOP;
        end
      end
      ST_NOP: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // pointer registers
  // ************************************************************
  // plain add finishes at the accepting edge and never leaves run
  assign add_en  = accept & (op == OP_ADD_PTR || op == OP_ADD_RET);
  assign add_sel = (op == OP_ADD_RET) ? 2'd2 : op_sel;

  // a bus write meeting an add to the same pointer is lost; software must
  // keep pointer writes clear of code that is adjusting them
  assign bus_wr = avs_write & ack_q;
  assign ptr_wr = bus_wr & (avs_address == OFS_PTR0 ||
                            avs_address == OFS_PTR1 ||
                            avs_address == OFS_PTR2);

  always_comb begin
    case (avs_address)
      OFS_PTR1: ptr_wr_sel = 2'd1;
      OFS_PTR2: ptr_wr_sel = 2'd2;
      default:  ptr_wr_sel = 2'd0;
    endcase
  end

  pai_ptr_file u_ptr (
    .clock   (clock),
    .rst_n   (rst_n),
    .add_en  (add_en),
    .add_sel (add_sel),
    .add_lit (op_lit),
    .wr_en   (ptr_wr),
    .wr_sel  (ptr_wr_sel),
    .wr_data (avs_writedata[PTR_W-1:0]),
    .ptr_q   (ptr_all)
  );

  assign ptr_reg_0       = ptr_all[0];
  assign ptr_reg_1       = ptr_all[1];
  assign pointer_reg_two = ptr_all[2];

  // ************************************************************
  // pc and return stack strobes
  // ************************************************************
  // one-cycle pulses in the cycle after acceptance, i.e. during the idle cycle;
  // the stack lives in the core, this unit only names value and direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= accept & is_two_cycle(op);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_pop_q <= 1'b0;
    end else begin
      stack_pop_q <= accept & (op == OP_ADD_RET);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_push_q <= 1'b0;
    end else begin
      stack_push_q <= accept & (op == OP_CALL_W);
    end
  end

  // no path here reaches the status flags or any shadow copy of w, status, bank
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_value_q <= '0;
    end else if (accept && op == OP_ADD_RET) begin
      pc_load_value_q <= top_of_return_stack;
    end else if (accept && op == OP_CALL_W) begin
      // old low byte is dropped, the latches supply the upper bytes
      pc_load_value_q <= {pc_upper_latch[4:0],
                          pc_high_latch,
                          working_reg_alias};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_push_value_q <= '0;
    end else if (accept && op == OP_CALL_W) begin
      stack_push_value_q <= pc_now + PC_STEP;
    end
  end

  assign pc_load          = pc_load_q;
  assign pc_load_value    = pc_load_value_q;
  assign stack_push       = stack_push_q;
  assign stack_push_value = stack_push_value_q;
  assign stack_pop        = stack_pop_q;

  // ************************************************************
  // control and status
  // ************************************************************
  // register map, byte offsets on the 32-bit slave port:
  //   00 control, bit 0 lets the extended words through, clear after reset
  //   04, 08, 0c pointers 0, 1 and 2, twelve bits, read and write
  //   10 status, bit 0 idle cycle under way, bit 1 sticky blocked flag
  //   14 claimed instruction count, sixteen bits, wraps
  //   other offsets read zero and ignore writes
  //
  // a software enable stands in for a configuration fuse so tests can flip it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_en_q <= CTRL_EXT_RST;
    end else if (bus_wr && avs_address == OFS_CTRL) begin
      ext_en_q <= avs_writedata[CTRL_EXT_BIT];
    end
  end

  // sticky: an extended word offered while disabled; write one to clear,
  // a fresh event in the clearing cycle keeps the flag set
  assign blocked_set = accept & ext_seen & ~ext_en_q;
  assign blocked_clr = bus_wr & (avs_address == OFS_STAT) & avs_writedata[STAT_BLOCKED_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blocked_q <= 1'b0;
    end else if (blocked_set) begin
      blocked_q <= 1'b1;
    end else if (blocked_clr) begin
      blocked_q <= 1'b0;
    end
  end

  // wraps silently; software compares differences, not absolute values
  assign count_d = count_q + 16'h0001;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RST;
    end else if (instr_claimed) begin
      count_q <= count_d;
    end
  end

  // ************************************************************
  // avalon slave
  // ************************************************************
  // fixed one wait state: ack rises on the first edge, which also captures
  // read data, so waitrequest is low for the second edge where a write lands;
  // a master that keeps its request up past that edge starts a new transfer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign rd_capture      = avs_read & ~ack_q;

  always_comb begin
    read_mux = 32'h00000000;
    case (avs_address)
      OFS_CTRL:  read_mux[CTRL_EXT_BIT] = ext_en_q;
      OFS_PTR0:  read_mux[PTR_W-1:0] = ptr_all[0];
      OFS_PTR1:  read_mux[PTR_W-1:0] = ptr_all[1];
      OFS_PTR2:  read_mux[PTR_W-1:0] = ptr_all[2];
      OFS_STAT: begin
        read_mux[STAT_BUSY_BIT]    = busy;
        read_mux[STAT_BLOCKED_BIT] = blocked_q;
      end
      OFS_COUNT: read_mux[15:0] = count_q;
      default:   read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // read data holds until the next read, so a late look still sees it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata_q <= 32'h00000000;
    end else if (rd_capture) begin
      readdata_q <= read_mux;
    end
  end

  assign avs_readdata = readdata_q;

endmodule // pai_ext_exec
`default_nettype wire

/* pai_pkg.sv */
// constants and types shared by the extended pointer/call execute unit
// assumes one core clock per instruction cycle and a 32-bit avalon slave port
package pai_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned PTR_W  = 12;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned LIT_W  = 6;
  localparam int unsigned ADDR_W = 5;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0]      ADD_LIT_TOP  = 8'he8;
  localparam logic [15:0]     CALL_W_WORD  = 16'h0014;
  localparam logic [3:0]      EXT_TOP_NIB  = 4'he;
  localparam logic [1:0]      RET_SEL      = 2'h3;
  localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;

  // ************************************************************
  // register map (byte offsets) and fields
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PTR0  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PTR1  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PTR2  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h14;

  localparam int unsigned CTRL_EXT_BIT     = 0;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_BLOCKED_BIT = 1;

  localparam logic             CTRL_EXT_RST = 1'b0;
  localparam logic [PTR_W-1:0] PTR_RST      = 12'h000;
  localparam logic [15:0]      COUNT_RST    = 16'h0000;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_ADD_PTR,
    OP_ADD_RET,
    OP_CALL_W
  } pai_op_t;

endpackage

/* pai_decode.sv */
// combinational opcode decoder for the three extended instructions
// assumes the instruction word is stable while instr_valid is high
`timescale 1ns/1ps
`default_nettype none
module pai_decode
  import pai_pkg::*;
(
  // instruction
  input  wire logic [15:0]      instr_word,
  input  wire logic             ext_en,
  // decoded fields
  output pai_op_t               op,
  output logic [1:0]            sel,
  output logic [LIT_W-1:0]      lit,
  output logic                  ext_seen
);

  function automatic logic is_add_lit(input logic [15:0] w);
    return w[15:8] == ADD_LIT_TOP;
  endfunction

  function automatic logic is_call_w(input logic [15:0] w);
    return w == CALL_W_WORD;
  endfunction

  assign sel = instr_word[7:6];
  assign lit = instr_word[5:0];
  // only the two shapes this unit handles; other extended words are not ours
  assign ext_seen = is_add_lit(instr_word) | is_call_w(instr_word);

  always_comb begin
    op = OP_NONE;
    if (ext_en) begin
      if (is_add_lit(instr_word)) begin
        op = (sel == RET_SEL) ? OP_ADD_RET : OP_ADD_PTR;
      end else if (is_call_w(instr_word)) begin
        op = OP_CALL_W;
      end
    end
  end

endmodule // pai_decode
`default_nettype wire

/* pai_ptr_file.sv */
// three indirect pointer registers with literal add and bus write
// assumes add and bus write may hit the same pointer in one cycle
`timescale 1ns/1ps
`default_nettype none
module pai_ptr_file
  import pai_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // literal add
  input  wire logic                  add_en,
  input  wire logic [1:0]            add_sel,
  input  wire logic [LIT_W-1:0]      add_lit,
  // bus write
  input  wire logic                  wr_en,
  input  wire logic [1:0]            wr_sel,
  input  wire logic [PTR_W-1:0]      wr_data,
  // pointer values
  output logic [2:0][PTR_W-1:0]      ptr_q
);

  logic [PTR_W-1:0] ptr_mem_q [3];

  for (genvar g = 0; g < 3; g++) begin : g_ptr
    // the instruction wins over a colliding bus write to keep program order
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        ptr_mem_q[g] <= PTR_RST;
      end else if (add_en && add_sel == 2'(g)) begin
        // unsigned literal, carry ripples into the upper bits
        ptr_mem_q[g] <= ptr_mem_q[g] + {{(PTR_W-LIT_W){1'b0}}, add_lit};
      end else if (wr_en && wr_sel == 2'(g)) begin
        ptr_mem_q[g] <= wr_data;
      end
    end
    assign ptr_q[g] = ptr_mem_q[g];
  end

endmodule // pai_ptr_file
`default_nettype wire

/* pai_fetch_model.sv */
// fetch path and core pc / return stack model facing the extended unit
// assumes the unit's pc and stack strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module pai_fetch_model
  import pai_pkg::*;
#(
  parameter logic [PC_W-1:0] RET0 = 21'h012340
)(
  // clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // fetch
  input  wire logic            instr_ready,
  output logic                 instr_valid,
  output logic [15:0]          instr_word,
  output logic [PC_W-1:0]      pc_now,
  // core control
  input  wire logic            pc_load,
  input  wire logic [PC_W-1:0] pc_load_value,
  input  wire logic            stack_push,
  input  wire logic [PC_W-1:0] stack_push_value,
  input  wire logic            stack_pop,
  output logic [PC_W-1:0]      top_of_return_stack
);
  // ********
  // core state
  // ********
  logic [PC_W-1:0] stk [8];
  int              sp;
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h5a5a;
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_now <= 21'h000100;
      stk[0] <= RET0;
      sp <= 1;
    end else begin
      if (pc_load) begin
        pc_now <= pc_load_value;
      end else if (instr_valid && instr_ready) begin
        pc_now <= pc_now + PC_STEP;
      end
      if (stack_push) begin
        stk[sp] <= stack_push_value;
        sp <= sp + 1;
      end else if (stack_pop && sp > 0) begin
        sp <= sp - 1;
      end
    end
  end
  assign top_of_return_stack = (sp > 0) ? stk[sp-1] : 21'h000000;
  // words are offered back to back; valid stays up across the idle cycle
  task automatic issue(input logic [15:0] w[$]);
    int n;
    @(posedge clock);
    foreach (w[i]) begin
      instr_valid <= 1'b1;
      instr_word <= w[i];
      n = 0;
      // a word is taken only at an edge where ready is seen high
      do begin
        @(posedge clock);
        n++;
      end while (instr_ready !== 1'b1 && n < 50);
    end
    instr_valid <= 1'b0;
    // a released word is scrambled so stale opcodes cannot pass
    instr_word <= ~instr_word;
  endtask
endmodule // pai_fetch_model
`default_nettype wire

/* pai_ext_exec_properties.sv */
// assertion checker for the extended pointer/call execute unit
// assumes it is bound to pai_ext_exec and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pai_ext_exec_properties
  import pai_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  // bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic              avs_waitrequest,
  // fetch and core state
  input wire logic              instr_valid,
  input wire logic [15:0]       instr_word,
  input wire logic              instr_ready,
  input wire logic              instr_claimed,
  input wire logic [PC_W-1:0]   pc_now,
  input wire logic [7:0]        working_reg_alias,
  input wire logic [7:0]        pc_high_latch,
  input wire logic [7:0]        pc_upper_latch,
  input wire logic [PC_W-1:0]   top_of_return_stack,
  // results
  input wire logic              pc_load,
  input wire logic [PC_W-1:0]   pc_load_value,
  input wire logic              stack_push,
  input wire logic [PC_W-1:0]   stack_push_value,
  input wire logic              stack_pop,
  input wire logic [PTR_W-1:0]  ptr_reg_0,
  input wire logic [PTR_W-1:0]  pointer_reg_two
);
  // ********
  // helpers
  // ********
  logic            ext_q;
  logic [5:0]      lit_q;
  logic [PC_W-1:0] tgt_q;
  wire acc = instr_valid & instr_ready & instr_claimed;
  wire addw = acc & (instr_word[15:8] == ADD_LIT_TOP);
  wire is_ret = addw & (instr_word[7:6] == RET_SEL);
  wire is_call = acc & (instr_word == CALL_W_WORD);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // enable mirror taken when the write completes; no fetch overlaps it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
      ext_q <= avs_writedata[CTRL_EXT_BIT];
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lit_q <= 6'h00;
      tgt_q <= '0;
    end else begin
      lit_q <= instr_word[5:0];
      tgt_q <= {pc_upper_latch[4:0], pc_high_latch, working_reg_alias};
    end
  end
  // ********
  // properties
  // ********
  property p_gate;
    instr_valid && !ext_q |-> !instr_claimed;
  endproperty
  a_gate: assert property (p_gate) else $error("word claimed while disabled");
  property p_add0;
    addw && instr_word[7:6] == 2'h0 |=> ptr_reg_0 == $past(ptr_reg_0) + {6'h00, lit_q};
  endproperty
  a_add0: assert property (p_add0) else $error("pointer 0 sum wrong");
  property p_plain;
    addw && !is_ret |=> !pc_load && !stack_pop && !stack_push && instr_ready;
  endproperty
  a_plain: assert property (p_plain) else $error("plain add not single cycle");
  property p_ret;
    is_ret |=> pc_load && stack_pop && !stack_push
      && pc_load_value == $past(top_of_return_stack);
  endproperty
  a_ret: assert property (p_ret) else $error("return not taken");
  property p_ret_ptr;
    is_ret |=> pointer_reg_two == $past(pointer_reg_two) + {6'h00, lit_q};
  endproperty
  a_ret_ptr: assert property (p_ret_ptr) else $error("pointer 2 sum wrong");
  property p_idle;
    is_ret || is_call |=> !instr_ready ##1 instr_ready;
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle wrong");
  property p_push;
    is_call |=> stack_push && !stack_pop && stack_push_value == $past(pc_now) + PC_STEP;
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");
  property p_target;
    is_call |=> pc_load && pc_load_value == tgt_q;
  endproperty
  a_target: assert property (p_target) else $error("call target wrong");
  property p_cause;
    pc_load |-> $past(is_ret) || $past(is_call);
  endproperty
  a_cause: assert property (p_cause) else $error("pc load without cause");
endmodule // pai_ext_exec_properties
bind pai_ext_exec pai_ext_exec_properties u_props (
  .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
  .instr_claimed(instr_claimed), .pc_now(pc_now), .working_reg_alias(working_reg_alias),
  .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
  .top_of_return_stack(top_of_return_stack), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .stack_push(stack_push),
  .stack_push_value(stack_push_value), .stack_pop(stack_pop), .ptr_reg_0(ptr_reg_0),
  .pointer_reg_two(pointer_reg_two)
);
`default_nettype wire

/* pai_ext_exec_bench.sv */
// self-checking bench for the extended pointer/call execute unit
// assumes the fetch model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module pai_ext_exec_bench
  import pai_pkg::*;
;
  localparam logic [PC_W-1:0] RET0 = 21'h012340;
  logic              clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, q;
  logic              instr_valid, instr_ready, instr_claimed, pc_load, stack_push, stack_pop;
  logic [15:0]       instr_word;
  logic [7:0]        working_reg_alias, pc_high_latch, pc_upper_latch;
  logic [PC_W-1:0]   pc_now, top_of_return_stack, pc_load_value, stack_push_value;
  logic [PTR_W-1:0]  ptr_reg_0, ptr_reg_1, pointer_reg_two;
  int                error_cnt, check_count;
  pai_ext_exec u_dut (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_claimed(instr_claimed), .pc_now(pc_now),
    .working_reg_alias(working_reg_alias), .pc_high_latch(pc_high_latch),
    .pc_upper_latch(pc_upper_latch), .top_of_return_stack(top_of_return_stack),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .stack_push(stack_push),
    .stack_push_value(stack_push_value), .stack_pop(stack_pop), .ptr_reg_0(ptr_reg_0),
    .ptr_reg_1(ptr_reg_1), .pointer_reg_two(pointer_reg_two));
  pai_fetch_model #(.RET0(RET0)) u_fetch (
    .clock(clock), .rst_n(rst_n), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word), .pc_now(pc_now), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .stack_push(stack_push),
    .stack_push_value(stack_push_value), .stack_pop(stack_pop),
    .top_of_return_stack(top_of_return_stack));
  always #12.5 clock = ~clock;
  // ********
  // shared tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_disabled();
    for (int i = 0; i < 6; i++) rd_chk("reset value", ADDR_W'(i * 4), 32'h0);
    u_fetch.issue('{16'he805, CALL_W_WORD});
    #1;
    chk("disabled pc load", pc_load, 1'b0);
    chk("disabled pointer", ptr_reg_0, 32'h0);
    rd_chk("blocked flag", OFS_STAT, 32'h2);
    bus(1'b1, OFS_STAT, 32'h2);
    rd_chk("blocked cleared", OFS_STAT, 32'h0);
  endtask
  task automatic t_add();
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_PTR2, 32'hffe);
    u_fetch.issue('{16'he83f, 16'he87f, 16'he8a3});
    #1;
    chk("pointer 0", ptr_reg_0, 32'h03f);
    chk("pointer 1", ptr_reg_1, 32'h03f);
    chk("pointer 2 wrap", pointer_reg_two, 32'h021);
    chk("add pc load", {pc_load, stack_pop, instr_ready}, 3'b001);
  endtask
  task automatic t_ret();
    bus(1'b1, OFS_PTR2, 32'h3ff);
    u_fetch.issue('{16'he8e3});
    #1;
    chk("return pointer", pointer_reg_two, 32'h422);
    chk("return strobes", {pc_load, stack_pop, stack_push}, 3'b110);
    chk("return target", pc_load_value, RET0);
    chk("return idle", instr_ready, 1'b0);
    @(posedge clock);
    #1;
    chk("return done", {instr_ready, pc_load, stack_pop}, 3'b100);
  endtask
  task automatic t_call();
    @(posedge clock);
    working_reg_alias <= 8'h06;
    pc_high_latch <= 8'h10;
    pc_upper_latch <= 8'he3;
    u_fetch.issue('{CALL_W_WORD});
    #1;
    chk("call strobes", {stack_push, pc_load, stack_pop}, 3'b110);
    chk("return address", stack_push_value, RET0 + PC_STEP);
    chk("call target", pc_load_value, 21'h031006);
    chk("call idle", instr_ready, 1'b0);
    @(posedge clock);
    #1;
    chk("call done", {instr_ready, pc_load, stack_push}, 3'b100);
    rd_chk("op count", OFS_COUNT, 32'h5);
    bus(1'b1, 5'h18, 32'hffffffff);
    rd_chk("unmapped", 5'h18, 32'h0);
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {working_reg_alias, pc_high_latch, pc_upper_latch} = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_disabled();
    t_add();
    t_ret();
    t_call();
    complete_run();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule // pai_ext_exec_bench
`default_nettype wire
